/* design/utbr_core.sv */
/*
  utbr_core: uart transmitter with break generation and 16x oversampled
  receiver with two-word fifo, overrun, framing and idle status.
  assumes: one clock, rx pin already synchronous, plain register port with
  read data one cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module utbr_core
  import utbr_pkg::*;
(
  input wire logic clk, // 10 MHz system clock
  input wire logic rst_n, // async reset, active low
  input wire logic [2:0] reg_addr, // register word address
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic rx_pin, // receive pin
  output logic tx_pin, // transmit pin
  output logic irq // combined interrupt request, high active
);

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_START = 2'b01,
    TX_DATA = 2'b10,
    TX_STOP = 2'b11
  } utbr_tx_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_WAITHI = 2'b11
  } utbr_rx_t;

  utbr_bus_t bus;
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] ctrl1_q;
  logic [7:0] ctrl2_q;
  logic [7:0] baud_q;
  logic txe_q, tidle_q, oerr_q, ferr_q, nf_q, ridle_q;
  logic st_seen_q; // status read armed the clear sequence
  logic [7:0] status;
  logic [1:0] fcount;
  utbr_word_t fhead;
  logic wr_data, rd_data, rd_status;

  assign wr_data = bus.wr && bus.addr == ADDR_DATA;
  assign rd_data = bus.rd && bus.addr == ADDR_DATA;
  assign rd_status = bus.rd && bus.addr == ADDR_STATUS;

  always_comb
  begin
    status = '0;
    status[ST_TXE] = txe_q;
    status[ST_TIDLE] = tidle_q;
    status[ST_RXAV] = fcount != 2'h0;
    status[ST_RIDLE] = ridle_q;
    status[ST_OERR] = oerr_q;
    status[ST_FERR] = fhead.ferr && fcount != 2'h0;
    status[ST_NF] = nf_q;
  end

  // ---------------------------------------------------------------
  // baud tick: one oversample tick every divider+1 clocks
  // ---------------------------------------------------------------
  logic [7:0] div_q;
  logic tick;
  assign tick = div_q == baud_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      div_q <= BAUD_RST;
    else
      div_q <= tick ? BAUD_RST : div_q + 8'h01;
  end

  // break request held longer than one divider period
  logic [7:0] brk_cnt_q;
  logic brk_arm_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      brk_cnt_q <= '0;
      brk_arm_q <= 1'b0;
    end
    else if (!ctrl2_q[C2_BRK])
    begin
      brk_cnt_q <= '0;
      brk_arm_q <= 1'b0;
    end
    else if (brk_cnt_q > baud_q)
      brk_arm_q <= 1'b1;
    else
      brk_cnt_q <= brk_cnt_q + 8'h01;
  end

  // ---------------------------------------------------------------
  // transmitter
  // ---------------------------------------------------------------
  utbr_tx_t tx_st_q;
  logic [8:0] tsr_q, tbuf_q;
  logic tbuf_full_q, tx_brk_q, stop2nd_q;
  logic [3:0] tx_ovs_q, tx_bit_q;
  logic tx_on, tx_load_buf;
  assign tx_on = ctrl2_q[C2_TXEN];
  assign tx_load_buf = tx_st_q == TX_STOP && tick && tx_ovs_q == OVS_LAST
                       && !(ctrl1_q[C1_STOP2] && !stop2nd_q) && tbuf_full_q;

  // frame sequencer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_st_q <= TX_IDLE;
      tsr_q <= '0;
      tx_ovs_q <= '0;
      tx_bit_q <= '0;
      tx_brk_q <= 1'b0;
      stop2nd_q <= 1'b0;
      tx_pin <= 1'b1;
    end
    else if (!tx_on)
    begin
      tx_st_q <= TX_IDLE;
      tx_pin <= 1'b1;
    end
    else
    begin
      unique case (tx_st_q)
        TX_IDLE:
        begin
          tx_pin <= 1'b1;
          if (brk_arm_q)
          begin
            tx_brk_q <= 1'b1;
            tx_st_q <= TX_START;
            tx_ovs_q <= '0;
          end
          else if (wr_data && txe_q)
          begin
            tsr_q <= {ctrl1_q[C1_TX9], bus.wdata};
            tx_brk_q <= 1'b0;
            tx_st_q <= TX_START;
            tx_ovs_q <= '0;
          end
          else if (tbuf_full_q)
          begin
            tsr_q <= tbuf_q;
            tx_brk_q <= 1'b0;
            tx_st_q <= TX_START;
            tx_ovs_q <= '0;
          end
        end
        TX_START:
        begin
          tx_pin <= 1'b0;
          if (tick)
          begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_ovs_q == OVS_LAST)
            begin
              tx_st_q <= TX_DATA;
              tx_bit_q <= '0;
            end
          end
        end
        TX_DATA:
        begin
          tx_pin <= tx_brk_q ? 1'b0 : tsr_q[0];
          if (tick)
          begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_ovs_q == OVS_LAST)
            begin
              if (!tx_brk_q)
                tsr_q <= {1'b0, tsr_q[8:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_brk_q && tx_bit_q == BRK_BITS - 4'h1)
              begin
                tx_bit_q <= '0;
                // another unit of thirteen zeros while break stays requested
                if (!ctrl2_q[C2_BRK])
                begin
                  tx_st_q <= TX_STOP;
                  stop2nd_q <= 1'b0;
                end
              end
              else if (!tx_brk_q && tx_bit_q == (ctrl1_q[C1_NINE] ? BITS9 : BITS8) - 4'h1)
              begin
                tx_st_q <= TX_STOP;
                stop2nd_q <= 1'b0;
              end
            end
          end
        end
        TX_STOP:
        begin
          tx_pin <= 1'b1;
          if (tick)
          begin
            tx_ovs_q <= tx_ovs_q + 4'h1;
            if (tx_ovs_q == OVS_LAST)
            begin
              if (ctrl1_q[C1_STOP2] && !stop2nd_q)
                stop2nd_q <= 1'b1;
              else if (tbuf_full_q)
              begin
                tsr_q <= tbuf_q;
                tx_brk_q <= 1'b0;
                tx_st_q <= TX_START;
              end
              else
                tx_st_q <= TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // buffer, empty and idle flags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tbuf_q <= '0;
      tbuf_full_q <= 1'b0;
      txe_q <= 1'b1;
      tidle_q <= 1'b1;
    end
    else
    begin
      if (wr_data && txe_q && st_seen_q)
      begin
        tidle_q <= 1'b0;
        if (tx_st_q != TX_IDLE || !tx_on)
        begin
          tbuf_q <= {ctrl1_q[C1_TX9], bus.wdata};
          tbuf_full_q <= 1'b1;
          txe_q <= 1'b0;
        end
      end
      else if (tx_load_buf || (tx_st_q == TX_IDLE && tx_on && tbuf_full_q && !brk_arm_q))
      begin
        tbuf_full_q <= 1'b0;
        txe_q <= 1'b1;
      end
      else if (tx_st_q == TX_STOP && tick && tx_ovs_q == OVS_LAST
               && !(ctrl1_q[C1_STOP2] && !stop2nd_q) && !tbuf_full_q)
        tidle_q <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  utbr_rx_t rx_st_q;
  logic [3:0] rx_ovs_q, rx_bit_q;
  logic [8:0] rsr_q;
  logic voted, rx_push_q, noisy_q, rx_on;
  utbr_word_t push_word_q;
  assign rx_on = ctrl2_q[C2_RXEN];

  // three samples around the bit centre
  utbr_vote u_vote (
    .clk(clk),
    .rst_n(rst_n),
    .pin(rx_pin),
    .sample(tick && rx_ovs_q >= OVS_MID - 4'h1 && rx_ovs_q <= OVS_MID + 4'h1),
    .level(voted)
  );

  // start search, bit shifting and stop check
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_q <= RX_HUNT;
      rx_ovs_q <= '0;
      rx_bit_q <= '0;
      rsr_q <= '0;
      ridle_q <= 1'b1;
      rx_push_q <= 1'b0;
      push_word_q <= '0;
    end
    else
    begin
      rx_push_q <= 1'b0;
      if (!rx_on)
      begin
        rx_st_q <= RX_HUNT;
        ridle_q <= 1'b1;
      end
      else
      begin
        if (tick)
          rx_ovs_q <= rx_ovs_q + 4'h1;
        unique case (rx_st_q)
          RX_HUNT:
            if (tick && !rx_pin)
            begin
              rx_st_q <= RX_START;
              rx_ovs_q <= 4'h1;
              ridle_q <= 1'b0;
            end
          RX_START:
            if (tick && rx_ovs_q == OVS_MID + 4'h2)
            begin
              if (voted)
              begin
                rx_st_q <= RX_HUNT;
                ridle_q <= 1'b1;
              end
            end
            else if (tick && rx_ovs_q == OVS_LAST)
            begin
              rx_st_q <= RX_DATA;
              rx_bit_q <= '0;
            end
          RX_DATA:
            if (tick && rx_ovs_q == OVS_MID + 4'h2)
            begin
              if (rx_bit_q == (ctrl1_q[C1_NINE] ? BITS9 : BITS8))
              begin
                // single stop bit only; zero there is a framing error
                push_word_q.data <= ctrl1_q[C1_NINE] ? rsr_q : {1'b0, rsr_q[8:1]};
                push_word_q.ferr <= !voted;
                push_word_q.nf <= noisy_q;
                rx_push_q <= 1'b1;
                ridle_q <= 1'b1;
                rx_st_q <= voted ? RX_HUNT : RX_WAITHI;
              end
              else
              begin
                rsr_q <= {voted, rsr_q[8:1]};
                rx_bit_q <= rx_bit_q + 4'h1;
              end
            end
          RX_WAITHI:
            if (tick && rx_pin)
              rx_st_q <= RX_HUNT;
        endcase
      end
    end
  end

  // disagreeing samples flag noise for the word
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      noisy_q <= 1'b0;
    else if (rx_st_q == RX_HUNT)
      noisy_q <= 1'b0;
    else if (tick && rx_ovs_q == OVS_MID + 4'h1 && rx_pin != voted)
      noisy_q <= 1'b1;
  end

  utbr_rx_fifo u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(!rx_on),
    .push(rx_push_q),
    .push_word(push_word_q),
    .pop(rd_data && st_seen_q),
    .head(fhead),
    .count(fcount)
  );

  // overrun and noise flags; a noise set beats the clear, a clearing read blocks the overrun set
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oerr_q <= 1'b0;
      nf_q <= 1'b0;
    end
    else
    begin
      if (rx_push_q && fcount == 2'h2 && !(rd_data && st_seen_q))
        oerr_q <= 1'b1;
      else if (rd_data && st_seen_q)
        oerr_q <= 1'b0;
      if (rx_push_q && push_word_q.nf)
        nf_q <= 1'b1;
      else if (rd_data && st_seen_q)
        nf_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl1_q <= '0;
      ctrl2_q <= '0;
      baud_q <= BAUD_RST;
    end
    else
    begin
      if (bus.wr && bus.addr == ADDR_CTRL1)
        ctrl1_q <= bus.wdata;
      else if (rx_push_q && fcount != 2'h2)
        ctrl1_q[C1_RX9] <= push_word_q.data[8] && ctrl1_q[C1_NINE];
      if (bus.wr && bus.addr == ADDR_CTRL2)
        ctrl2_q <= bus.wdata;
      if (bus.wr && bus.addr == ADDR_BAUD)
        baud_q <= bus.wdata;
    end
  end

  // clear sequence arming and read data
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_seen_q <= 1'b0;
      reg_rdata <= '0;
    end
    else
    begin
      if (rd_status)
        st_seen_q <= 1'b1;
      else if (wr_data || rd_data)
        st_seen_q <= 1'b0;
      reg_rdata <= '0; // unmapped reads give zero
      if (bus.rd)
        unique case (bus.addr)
          ADDR_STATUS: reg_rdata <= status;
          ADDR_DATA: reg_rdata <= fhead.data[7:0];
          ADDR_CTRL1: reg_rdata <= ctrl1_q;
          ADDR_CTRL2: reg_rdata <= ctrl2_q;
          ADDR_BAUD: reg_rdata <= baud_q;
          default: reg_rdata <= '0;
        endcase
    end
  end

  // interrupt: tx empty is gated off by tx_brk_q, so break frames raise no empty request
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= (ctrl2_q[C2_TEIE] && txe_q && !tx_brk_q)
             || (ctrl2_q[C2_RIE] && (rx_push_q || oerr_q || fcount != 2'h0));
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  tx_idle_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    $past(tx_st_q) == TX_IDLE && $past(tx_on) |-> tx_pin)
    else $error("tx pin low while idle");
  overrun_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_push_q && fcount == 2'h2 && !rd_data |=> oerr_q)
    else $error("overrun not flagged");
  rx_avail_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_push_q && fcount == 2'h0 |=> status[ST_RXAV])
    else $error("data flag missing after push");
  rx_idle_start_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_st_q == RX_HUNT && rx_on && tick && !rx_pin |=> !ridle_q)
    else $error("rx idle not cleared at start");
  ferr_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    rx_push_q && push_word_q.ferr && rx_on |-> rx_st_q == RX_WAITHI)
    else $error("no wait after framing error");
  tx_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_data && txe_q && st_seen_q |=> !tidle_q)
    else $error("tx idle not cleared");
  brk_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    tx_st_q == TX_DATA && tx_brk_q && tx_on |=> !tx_pin)
    else $error("break bit not zero");
  brk_arm_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ctrl2_q[C2_BRK] |=> !brk_arm_q)
    else $error("break armed without request");

endmodule : utbr_core
`default_nettype wire

/* design/utbr_pkg.sv */
/*
  utbr_pkg: constants, register offsets and carrier types for the uart
  transmit-break and receive block.
  assumes: included before every other design file of the block.
*/
package utbr_pkg;

  // ---------------------------------------------------------------
  // register map (word addresses on the plain register port)
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_STATUS = 3'h0; // serial_status_reg
  localparam logic [2:0] ADDR_DATA = 3'h1; // serial_data_reg
  localparam logic [2:0] ADDR_CTRL1 = 3'h2; // serial_control_reg_one
  localparam logic [2:0] ADDR_CTRL2 = 3'h3; // enables and break control
  localparam logic [2:0] ADDR_BAUD = 3'h4; // baud_divider_reg

  // ---------------------------------------------------------------
  // status bit positions
  // ---------------------------------------------------------------
  localparam int ST_PERR = 0;
  localparam int ST_NF = 1;
  localparam int ST_FERR = 2;
  localparam int ST_OERR = 3;
  localparam int ST_RIDLE = 4;
  localparam int ST_RXAV = 5;
  localparam int ST_TIDLE = 6;
  localparam int ST_TXE = 7;

  // control one bit positions
  localparam int C1_RX9 = 0;
  localparam int C1_TX9 = 1;
  localparam int C1_STOP2 = 2;
  localparam int C1_NINE = 6;

  // control two bit positions
  localparam int C2_TXEN = 0;
  localparam int C2_RXEN = 1;
  localparam int C2_BRK = 2;
  localparam int C2_TEIE = 3;
  localparam int C2_RIE = 4;

  // ---------------------------------------------------------------
  // timing and widths
  // ---------------------------------------------------------------
  localparam logic [3:0] OVS_LAST = 4'hf; // sixteen ticks per bit
  localparam logic [3:0] OVS_MID = 4'h7; // centre sample tick
  localparam logic [3:0] BRK_BITS = 4'hd; // thirteen zero bits per break unit
  localparam logic [3:0] BITS8 = 4'h8;
  localparam logic [3:0] BITS9 = 4'h9;
  localparam logic [7:0] BAUD_RST = 8'h00;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } utbr_bus_t;

  typedef struct packed {
    logic [8:0] data;
    logic ferr;
    logic nf;
  } utbr_word_t;

endpackage : utbr_pkg

/* design/utbr_rx_fifo.sv */
/*
  utbr_rx_fifo: two-entry receive word store in flip-flops.
  assumes: push and pop are single-cycle pulses in the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module utbr_rx_fifo
  import utbr_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic flush, // empty the store
  input wire logic push, // write one word
  input wire utbr_word_t push_word, // word to write
  input wire logic pop, // drop the head word
  output utbr_word_t head, // oldest word
  output logic [1:0] count // words held
);

  utbr_word_t mem_q [2];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  logic do_push;
  logic do_pop;

  assign do_pop = pop && (cnt_q != 2'h0);
  // a full store refuses the push unless a pop comes in the same cycle; the caller flags overrun
  assign do_push = push && (cnt_q != 2'h2 || do_pop);
  assign head = mem_q[rp_q];
  assign count = cnt_q;

  // storage, addressed by write index
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end
    else if (do_push)
      mem_q[wp_q] <= push_word;
  end

  // pointers and fill count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else if (flush)
    begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      if (do_push)
        wp_q <= ~wp_q;
      if (do_pop)
        rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, do_push} - {1'b0, do_pop};
    end
  end

endmodule : utbr_rx_fifo
`default_nettype wire

/* design/utbr_vote.sv */
/*
  utbr_vote: three-sample majority detector on the receive pin.
  assumes: sample is a one-cycle strobe from the oversampling counter.
*/
`timescale 1ns/1ps
`default_nettype none
module utbr_vote
  import utbr_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic pin, // receive pin level
  input wire logic sample, // take one sample
  output logic level // majority of last three samples
);

  logic [2:0] sh_q;

  // three-deep history; idle line is high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sh_q <= 3'h7;
    else if (sample)
      sh_q <= {sh_q[1:0], pin};
  end

  // majority of three
  assign level = (sh_q[0] & sh_q[1]) | (sh_q[0] & sh_q[2]) | (sh_q[1] & sh_q[2]);

endmodule : utbr_vote
`default_nettype wire

/* verif/uart_tx_break_and_receiver_bench.sv */
/*
  bench: register tasks, queued expectations, echo node on the line.
  assumes: baud divider 0, so one bit is sixteen clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module uart_tx_break_and_receiver_bench
  import utbr_pkg::*;
;
  logic clk, rst_n, reg_wr, reg_rd, tx_pin, rx_pin, irq, got_stb, rd_seen;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, got, rd_last;
  logic [7:0] b[3];
  logic [15:0] rq[$];
  logic [7:0] tq[$];
  logic [15:0] rm;
  int failures, tests_run, seed, n;
  // ----------------------------------------
  // clock, instances
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  utbr_core dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .irq(irq));
  utbr_node node (.tx_pin(tx_pin), .rx_pin(rx_pin), .got(got), .got_stb(got_stb));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // mask zero means the read is only a poll
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
    rq.push_back({e, m});
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask : rd
  task automatic wait_txe;
    n = 0;
    do
    begin
      rd(ADDR_STATUS, 8'h00, 8'h00);
      @(negedge clk);
      #1 n++;
    end while (rd_last[ST_TXE] !== 1'b1 && n < 2000);
  endtask : wait_txe
  task automatic tally_and_finish;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // read data stands only in the cycle after the strobe
  always @(posedge clk) rd_seen <= reg_rd;
  always @(negedge clk)
  begin
    if (rd_seen === 1'b1)
    begin
      rd_last = reg_rdata;
      rm = rq.pop_front();
      if (rm[7:0] != 8'h00)
        chk({8'h00, reg_rdata & rm[7:0]}, {8'h00, rm[15:8]});
    end
  end
  always @(posedge got_stb)
    if (tq.size() > 0)
      chk({8'h00, got}, {8'h00, tq.pop_front()});
  initial
  begin
    #(100 * 8000);
    failures++;
    tally_and_finish;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = 32'hf144;
    failures = 0;
    tests_run = 0;
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_STATUS, 8'hd0, 8'hff);
    rd(3'h7, 8'h00, 8'hff);
    wr(ADDR_BAUD, 8'h00);
    wr(ADDR_CTRL2, 8'h13);
    // three words back to back; the echoes overrun the fifo
    for (int k = 0; k < 3; k++)
    begin
      n = $random(seed);
      b[k] = n[7:0];
      wait_txe;
      wr(ADDR_DATA, b[k]);
      tq.push_back(b[k]);
      rd(ADDR_STATUS, (k == 0) ? 8'h80 : 8'h00, 8'hc0);
    end
    repeat (1000) @(posedge clk);
    chk({15'h0, irq}, 16'h1);
    rd(ADDR_STATUS, 8'hf8, 8'hfc);
    rd(ADDR_DATA, b[0], 8'hff);
    rd(ADDR_STATUS, 8'h00, 8'h00);
    rd(ADDR_DATA, b[1], 8'hff);
    rd(ADDR_STATUS, 8'h00, 8'h20);
    // break with the empty interrupt enabled, receiver off; the line is
    // idle when break is requested so the whole low span can be counted
    wr(ADDR_CTRL2, 8'h09);
    wait_txe;
    wr(ADDR_CTRL2, 8'h0d);
    fork
      begin
        // a word queued behind the break, then the break released early
        wait_txe;
        wr(ADDR_DATA, 8'h00);
        repeat (40) @(posedge clk);
        wr(ADDR_CTRL2, 8'h09);
      end
    join_none
    // pin is sampled on the falling edge, clear of the launching edge
    n = 0;
    while (tx_pin !== 1'b0 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (tx_pin === 1'b0 && n < 2000)
    begin
      @(negedge clk);
      n++;
      if (n == 100)
        chk({15'h0, irq}, 16'h0);
    end
    chk(n[15:0], 16'd224);
    repeat (40) @(posedge clk);
    chk({15'h0, irq}, 16'h1);
    // the queued word must finish before the idle flag comes back
    repeat (200) @(posedge clk);
    rd(ADDR_STATUS, 8'hc0, 8'hc0);
    repeat (4) @(posedge clk);
    tally_and_finish;
  end
endmodule : uart_tx_break_and_receiver_bench
`default_nettype wire

/* verif/utbr_node.sv */
/*
  utbr_node: far serial node, decodes words from tx and echoes them on rx.
  assumes: 8n1 frames, bit time of BIT_NS, line idles high.
*/
`timescale 1ns/1ps
`default_nettype none
module utbr_node
  import utbr_pkg::*;
#(
  parameter int BIT_NS = 1600
)
(
  input wire logic tx_pin, // line from the block
  output logic rx_pin, // line into the block
  output logic [7:0] got, // last word decoded
  output logic got_stb // pulse per decoded word
);
  logic [7:0] eq[$];
  logic [7:0] w;
  logic [7:0] e;
  // ----------------------------------------
  // decode at mid-bit, lsb first
  // ----------------------------------------
  initial
  begin
    got_stb = 1'b0;
    got = 8'h00;
    forever
    begin
      @(negedge tx_pin);
      #(BIT_NS / 2);
      for (int i = 0; i < 8; i++)
      begin
        #(BIT_NS);
        w[i] = tx_pin;
      end
      #(BIT_NS);
      got = w;
      eq.push_back(w);
      got_stb = 1'b1;
      #10 got_stb = 1'b0;
    end
  end
  // echo, queued so words can pile up at the receiver
  initial
  begin
    rx_pin = 1'b1;
    forever
    begin
      wait (eq.size() > 0);
      e = eq.pop_front();
      rx_pin = 1'b0;
      #(BIT_NS);
      for (int i = 0; i < 8; i++)
      begin
        rx_pin = e[i];
        #(BIT_NS);
      end
      rx_pin = 1'b1; // pulled-up idle level
      #(BIT_NS);
    end
  end
endmodule : utbr_node
`default_nettype wire
